// file: include/sdm_regs.svh
// Purpose: Offsets, field positions, reset values and codes of the
//          converter mode controller.
// Assumes: Byte-wide special function register space.
// Notes: Definitions only.
`ifndef SDM_REGS_SVH
`define SDM_REGS_SVH

`define SDM_ADR_INPUT_CFG 8'hd2
`define SDM_ADR_OP_CTRL 8'hd1
`define SDM_ADR_CHAN_SEL 8'hd3
`define SDM_ADR_DECIM 8'hd4
`define SDM_ADR_STATUS 8'hd8
`define SDM_ADR_RES_L 8'hd9
`define SDM_ADR_RES_M 8'hda
`define SDM_ADR_RES_H 8'hdb
`define SDM_ADR_OFS_L 8'he1
`define SDM_ADR_OFS_M 8'he2
`define SDM_ADR_OFS_H 8'he3
`define SDM_ADR_GAIN_L 8'he4
`define SDM_ADR_GAIN_M 8'he5
`define SDM_ADR_GAIN_H 8'he6

`define SDM_RST_INPUT_CFG 8'h07
`define SDM_RST_OP_CTRL 8'h10
`define SDM_RST_CHAN_SEL 8'h00
`define SDM_RST_DECIM 8'h45
`define SDM_RST_STATUS 8'h00

`define SDM_BIT_NOTCH 6
`define SDM_BIT_ENABLE 4
`define SDM_BIT_CHOP_DIS 3
`define SDM_BIT_UNI 5
`define SDM_BIT_READY 7
`define SDM_BIT_CAL 5
`define SDM_BIT_NOXREF 4
`define SDM_BIT_ERR 3

`define SDM_DECIM_MIN_CHOP 8'h0d
`define SDM_DECIM_MIN_NOCHOP 8'h03
`define SDM_ZERO_BIPOLAR 24'h800000

`endif

// file: include/sdm_pkg.sv
// Purpose: Types shared by the converter mode controller.
// Assumes: Nothing.
// Notes: Codes match the three-bit operating field.
package sdm_pkg;

  typedef enum logic [2:0] {
    OP_POWER_DOWN = 3'b000,
    OP_IDLE = 3'b001,
    OP_SINGLE = 3'b010,
    OP_CONTINUOUS = 3'b011,
    OP_CAL_INT_ZERO = 3'b100,
    OP_CAL_INT_FULL = 3'b101,
    OP_CAL_SYS_ZERO = 3'b110,
    OP_CAL_SYS_FULL = 3'b111
  } sdm_op_t;

  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } sdm_state_t;

  // Settings handed to the analog modulator and filter.
  typedef struct packed {
    logic power;
    logic filt_hold;
    logic conv_reset;
    logic chop_en;
    logic notch_en;
    logic [1:0] buffer_cfg;
    logic [2:0] range_code;
    logic [1:0] ref_sel;
    logic [3:0] input_pair;
    logic input_short;
    logic ref_to_input;
    logic [7:0] decim;
  } sdm_analog_t;

endpackage

// file: design/sdm_mode_control.sv
// Purpose: Mode, calibration and result control of a sigma-delta
//          converter, reached through byte-wide function registers.
// Assumes: Filter data and modulator ticks arrive on ref_clk; the
//          reference-detect pin is asynchronous.
// Notes: Register read data appears one cycle after the read strobe.
`timescale 1ns/1ps
`include "sdm_regs.svh"

module sdm_mode_control #(
  parameter int RES_W = 24
) (
  // Clock, reset and freeze.
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Function register port.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Modulator and filter side.
  input wire logic mod_tick,
  input wire logic [RES_W-1:0] filt_data,
  input wire logic noxref_pin,
  output sdm_pkg::sdm_analog_t ana,
  output logic done_pulse
);

  initial begin
    if (RES_W != 24) begin
      $error("sdm_mode_control serves only a 24-bit result");
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers and their next values.

  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] chan_r, chan_nxt;
  logic [7:0] decim_r, decim_nxt;
  logic notch_r, notch_nxt;
  logic enable_r, enable_nxt;
  logic chop_dis_r, chop_dis_nxt;
  sdm_pkg::sdm_op_t op_r, op_nxt;
  sdm_pkg::sdm_state_t st_r, st_nxt;
  logic ready_r, ready_nxt;
  logic cal_r, cal_nxt;
  logic err_r, err_nxt;
  logic [23:0] res_r, res_nxt;
  logic [23:0] ofs_r, ofs_nxt;
  logic [23:0] gain_r, gain_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic [7:0] rdata_nxt;
  sdm_pkg::sdm_analog_t ana_nxt;
  logic done_nxt;
  logic nx_meta_r, nx_sync_r;

  logic wr_op, wr_stat, sample, clamp;
  logic [7:0] decim_eff;
  logic [11:0] target;
  logic [23:0] coded;

  function automatic logic is_start(input logic [2:0] code);
    is_start = code[2] | code[1];
  endfunction

  function automatic logic is_cal(input logic [2:0] code);
    is_cal = code[2];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Reference-detect synchroniser.

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nx_meta_r <= 1'b0;
      nx_sync_r <= 1'b0;
    end else if (ce) begin
      nx_meta_r <= noxref_pin;
      nx_sync_r <= nx_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Conversion timing and result coding.

  always_comb begin
    wr_op = sfr_wr && (sfr_addr == `SDM_ADR_OP_CTRL);
    wr_stat = sfr_wr && (sfr_addr == `SDM_ADR_STATUS);
    // Word limits depend on chopping; calibration uses it too.
    decim_eff = decim_r;
    if (!chop_dis_r && decim_r < `SDM_DECIM_MIN_CHOP) begin
      decim_eff = `SDM_DECIM_MIN_CHOP;
    end else if (chop_dis_r && decim_r < `SDM_DECIM_MIN_NOCHOP) begin
      decim_eff = `SDM_DECIM_MIN_NOCHOP;
    end
    // Chopping takes two filter passes per result.
    target = chop_dis_r ? {1'b0, decim_eff, 3'b000} :
      {decim_eff, 4'b0000};
    sample = (st_r == sdm_pkg::ST_RUN) && mod_tick &&
      (cnt_r == target - 12'h001) && !wr_op;
    clamp = 1'b0;
    if (nx_sync_r) begin
      coded = 24'hffffff;
      clamp = 1'b1;
    end else if (cfg_r[`SDM_BIT_UNI]) begin
      if (filt_data[23]) begin
        coded = 24'h000000;
        clamp = 1'b1;
      end else begin
        coded = {filt_data[22:0], 1'b0};
      end
    end else begin
      coded = filt_data ^ `SDM_ZERO_BIPOLAR;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode sequencing, status and result registers.

  always_comb begin
    cfg_nxt = cfg_r;
    chan_nxt = chan_r;
    decim_nxt = decim_r;
    notch_nxt = notch_r;
    enable_nxt = enable_r;
    chop_dis_nxt = chop_dis_r;
    op_nxt = op_r;
    st_nxt = st_r;
    ready_nxt = ready_r;
    cal_nxt = cal_r;
    err_nxt = err_r;
    res_nxt = res_r;
    ofs_nxt = ofs_r;
    gain_nxt = gain_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (sfr_wr) begin
      case (sfr_addr)
        `SDM_ADR_INPUT_CFG: cfg_nxt = sfr_wdata & 8'he7;
        `SDM_ADR_CHAN_SEL: chan_nxt = sfr_wdata & 8'hcf;
        `SDM_ADR_DECIM: decim_nxt = sfr_wdata;
        default: begin
        end
      endcase
    end
    if (wr_stat && !sfr_wdata[`SDM_BIT_READY]) begin
      ready_nxt = 1'b0;
    end
    if (st_r == sdm_pkg::ST_RUN && mod_tick) begin
      cnt_nxt = (cnt_r == target - 12'h001) ? 12'h000 :
        cnt_r + 12'h001;
    end
    if (sample) begin
      done_nxt = 1'b1;
      if (is_cal(op_r)) begin
        if (!ready_r) begin
          if (nx_sync_r) begin
            err_nxt = 1'b1;
          end else if (op_r[0]) begin
            gain_nxt = filt_data;
          end else begin
            ofs_nxt = filt_data;
          end
        end
        cal_nxt = 1'b1;
        op_nxt = sdm_pkg::OP_POWER_DOWN;
        st_nxt = sdm_pkg::ST_STOP;
      end else begin
        if (!ready_r) begin
          res_nxt = coded;
          err_nxt = clamp;
        end
        if (op_r == sdm_pkg::OP_SINGLE) begin
          op_nxt = sdm_pkg::OP_POWER_DOWN;
          st_nxt = sdm_pkg::ST_STOP;
        end
      end
      ready_nxt = 1'b1;
    end
    if (wr_op) begin
      notch_nxt = sfr_wdata[`SDM_BIT_NOTCH];
      enable_nxt = sfr_wdata[`SDM_BIT_ENABLE];
      chop_dis_nxt = sfr_wdata[`SDM_BIT_CHOP_DIS];
      op_nxt = sdm_pkg::sdm_op_t'(sfr_wdata[2:0]);
      cnt_nxt = 12'h000;
      if (is_start(sfr_wdata[2:0])) begin
        ready_nxt = 1'b0;
        cal_nxt = 1'b0;
        err_nxt = 1'b0;
      end
      if (!sfr_wdata[`SDM_BIT_ENABLE]) begin
        st_nxt = sdm_pkg::ST_STOP;
      end else if (is_start(sfr_wdata[2:0])) begin
        st_nxt = sdm_pkg::ST_RUN;
      end else if (sfr_wdata[2:0] == 3'b001) begin
        st_nxt = sdm_pkg::ST_IDLE;
      end else begin
        st_nxt = sdm_pkg::ST_STOP;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= `SDM_RST_INPUT_CFG;
      chan_r <= `SDM_RST_CHAN_SEL;
      decim_r <= `SDM_RST_DECIM;
      notch_r <= 1'b0;
      enable_r <= 1'b1;
      chop_dis_r <= 1'b0;
      op_r <= sdm_pkg::OP_POWER_DOWN;
      st_r <= sdm_pkg::ST_STOP;
      ready_r <= 1'b0;
      cal_r <= 1'b0;
      err_r <= 1'b0;
      res_r <= 24'h000000;
      ofs_r <= 24'h000000;
      gain_r <= 24'h000000;
      cnt_r <= 12'h000;
      done_pulse <= 1'b0;
    end else if (ce) begin
      cfg_r <= cfg_nxt;
      chan_r <= chan_nxt;
      decim_r <= decim_nxt;
      notch_r <= notch_nxt;
      enable_r <= enable_nxt;
      chop_dis_r <= chop_dis_nxt;
      op_r <= op_nxt;
      st_r <= st_nxt;
      ready_r <= ready_nxt;
      cal_r <= cal_nxt;
      err_r <= err_nxt;
      res_r <= res_nxt;
      ofs_r <= ofs_nxt;
      gain_r <= gain_nxt;
      cnt_r <= cnt_nxt;
      done_pulse <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register read-back and analog settings.

  always_comb begin
    rdata_nxt = sfr_rdata;
    if (sfr_rd) begin
      case (sfr_addr)
        `SDM_ADR_INPUT_CFG: rdata_nxt = cfg_r;
        `SDM_ADR_OP_CTRL: rdata_nxt = {1'b0, notch_r, 1'b0, enable_r,
          chop_dis_r, op_r};
        `SDM_ADR_CHAN_SEL: rdata_nxt = chan_r;
        `SDM_ADR_DECIM: rdata_nxt = decim_r;
        `SDM_ADR_STATUS: rdata_nxt = {ready_r, 1'b0, cal_r, nx_sync_r,
          err_r, 3'b000};
        `SDM_ADR_RES_L: rdata_nxt = res_r[7:0];
        `SDM_ADR_RES_M: rdata_nxt = res_r[15:8];
        `SDM_ADR_RES_H: rdata_nxt = res_r[23:16];
        `SDM_ADR_OFS_L: rdata_nxt = ofs_r[7:0];
        `SDM_ADR_OFS_M: rdata_nxt = ofs_r[15:8];
        `SDM_ADR_OFS_H: rdata_nxt = ofs_r[23:16];
        `SDM_ADR_GAIN_L: rdata_nxt = gain_r[7:0];
        `SDM_ADR_GAIN_M: rdata_nxt = gain_r[15:8];
        `SDM_ADR_GAIN_H: rdata_nxt = gain_r[23:16];
        default: rdata_nxt = 8'h00;
      endcase
    end
    ana_nxt.power = (st_r != sdm_pkg::ST_STOP);
    ana_nxt.filt_hold = (st_r != sdm_pkg::ST_RUN);
    ana_nxt.conv_reset = wr_op;
    ana_nxt.chop_en = !chop_dis_r;
    ana_nxt.notch_en = notch_r;
    ana_nxt.buffer_cfg = cfg_r[7:6];
    ana_nxt.range_code = cfg_r[2:0];
    ana_nxt.ref_sel = chan_r[7:6];
    ana_nxt.input_pair = chan_r[3:0];
    ana_nxt.input_short = (op_r == sdm_pkg::OP_CAL_INT_ZERO);
    ana_nxt.ref_to_input = (op_r == sdm_pkg::OP_CAL_INT_FULL);
    ana_nxt.decim = decim_eff;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      ana <= '0;
    end else if (ce) begin
      sfr_rdata <= rdata_nxt;
      ana <= ana_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks.

  property p_power_off;
    @(posedge ref_clk) disable iff (rst)
    ce && wr_op && !sfr_wdata[`SDM_BIT_ENABLE] ##1 ce |=> !ana.power;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("converter powered while disabled");

  property p_idle_hold;
    @(posedge ref_clk) disable iff (rst)
    ce && wr_op && sfr_wdata[4] && sfr_wdata[2:0] == 3'b001 ##1 ce
      |=> ana.power && ana.filt_hold;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("idle mode does not hold filter");

  property p_single_end;
    @(posedge ref_clk) disable iff (rst)
    ce && sample && op_r == sdm_pkg::OP_SINGLE |=>
      op_r == sdm_pkg::OP_POWER_DOWN && st_r == sdm_pkg::ST_STOP;
  endproperty
  a_single_end: assert property (p_single_end)
    else $error("single conversion did not return to power-down");

  property p_op_reset;
    @(posedge ref_clk) disable iff (rst)
    ce && wr_op |=> cnt_r == 12'h000 && ana.conv_reset;
  endproperty
  a_op_reset: assert property (p_op_reset)
    else $error("operating code write did not reset converter");

  property p_cal_clear;
    @(posedge ref_clk) disable iff (rst)
    ce && wr_op && sfr_wdata[2] |=> !ready_r && !cal_r;
  endproperty
  a_cal_clear: assert property (p_cal_clear)
    else $error("calibration start left ready flag set");

  property p_cal_done;
    @(posedge ref_clk) disable iff (rst)
    ce && sample && is_cal(op_r) |=> ready_r && cal_r && op_r == 3'b000;
  endproperty
  a_cal_done: assert property (p_cal_done)
    else $error("calibration end flags wrong");

  property p_hold_result;
    @(posedge ref_clk) disable iff (rst)
    ready_r |=> $stable(res_r) && $stable(ofs_r) && $stable(gain_r);
  endproperty
  a_hold_result: assert property (p_hold_result)
    else $error("result written while ready flag set");

  property p_err_clear;
    @(posedge ref_clk) disable iff (rst)
    ce && wr_op && is_start(sfr_wdata[2:0]) |=> !err_r;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("start write left error flag set");

  property p_bipolar_zero;
    @(posedge ref_clk) disable iff (rst)
    ce && sample && !ready_r && !is_cal(op_r) && !nx_sync_r &&
      !cfg_r[`SDM_BIT_UNI] && filt_data == 24'h000000
      |=> res_r == 24'h800000;
  endproperty
  a_bipolar_zero: assert property (p_bipolar_zero)
    else $error("bipolar zero not coded mid-scale");

  property p_chop;
    @(posedge ref_clk) disable iff (rst)
    ce ##1 ce |-> ana.chop_en == !$past(chop_dis_r);
  endproperty
  a_chop: assert property (p_chop)
    else $error("chop setting not applied");

  c_single: cover property (@(posedge ref_clk) disable iff (rst)
    sample && op_r == sdm_pkg::OP_SINGLE);
  c_cal: cover property (@(posedge ref_clk) disable iff (rst)
    sample && is_cal(op_r));
  c_cont: cover property (@(posedge ref_clk) disable iff (rst)
    sample && op_r == sdm_pkg::OP_CONTINUOUS && ready_r);
  c_idle: cover property (@(posedge ref_clk) disable iff (rst)
    st_r == sdm_pkg::ST_IDLE);

endmodule

// file: sim/sdm_mode_control_tb.sv
// Purpose: Self-checking bench of the converter mode controller.
// Assumes: Property checks travel inside the design files.
// Notes: Read data is checked against a queue of expected bytes.
`timescale 1ns/1ps
`include "sdm_regs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module sdm_mode_control_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic mod_tick = 1'b0;
  logic [23:0] filt_data = 24'h000000;
  logic noxref_pin = 1'b0;
  sdm_pkg::sdm_analog_t ana;
  logic done_pulse;
  int mismatches = 0;
  int checks_done = 0;
  int seen = 0;
  int nrst = 0;
  logic [7:0] exp_q[$];
  logic [7:0] exp_b;
  logic rd_pend = 1'b0;
  logic [23:0] raw;
  logic [7:0] cfg;
  logic [7:0] ch;

  always #25 ref_clk = ~ref_clk;

  sdm_mode_control uut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .mod_tick(mod_tick), .filt_data(filt_data),
    .noxref_pin(noxref_pin), .ana(ana), .done_pulse(done_pulse)
  );

  ////////////////////////////////////////////////////////////////////
  // Read data stands one cycle after the read edge.
  always @(posedge ref_clk) begin
    if (rd_pend) begin
      exp_b = exp_q.pop_front();
      `CHK("rdata", exp_b, sfr_rdata)
    end
    if (done_pulse === 1'b1) seen++;
    if (ana.conv_reset === 1'b1) nrst++;
    rd_pend <= sfr_rd;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
  endtask

  task automatic rd24(input logic [7:0] b, input logic [23:0] v);
    rd(b, v[7:0]);
    rd(8'(b + 8'h01), v[15:8]);
    rd(8'(b + 8'h02), v[23:16]);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      mod_tick <= 1'b1;
      @(posedge ref_clk);
      mod_tick <= 1'b0;
    end
  endtask

  // One conversion of n ticks: nothing before the last, one done after.
  task automatic run(input int n);
    seen = 0;
    ticks(n - 1);
    repeat (3) @(posedge ref_clk);
    `CHK("early", 0, seen)
    ticks(1);
    repeat (3) @(posedge ref_clk);
    `CHK("done", 1, seen)
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    cfg = 8'($urandom(32'h21d0));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`SDM_ADR_INPUT_CFG, `SDM_RST_INPUT_CFG);
    rd(`SDM_ADR_OP_CTRL, `SDM_RST_OP_CTRL);
    rd(`SDM_ADR_CHAN_SEL, `SDM_RST_CHAN_SEL);
    rd(`SDM_ADR_DECIM, `SDM_RST_DECIM);
    rd(`SDM_ADR_STATUS, `SDM_RST_STATUS);
    rd(8'h80, 8'h00);
    `CHK("power", 1'b0, ana.power)
    $display("test reset values done");
    for (int i = 0; i < 3; i++) begin
      cfg = (8'($urandom) & 8'h3f) | 8'(i << 6);
      ch = (8'($urandom) & 8'h3f) | 8'(i << 6);
      wr(`SDM_ADR_INPUT_CFG, cfg);
      wr(`SDM_ADR_CHAN_SEL, ch);
      rd(`SDM_ADR_INPUT_CFG, cfg & 8'he7);
      rd(`SDM_ADR_CHAN_SEL, ch & 8'hcf);
      `CHK("buf", cfg[7:6], ana.buffer_cfg)
      `CHK("range", cfg[2:0], ana.range_code)
      `CHK("ref", ch[7:6], ana.ref_sel)
      `CHK("pair", ch[3:0], ana.input_pair)
    end
    $display("test config fields done");
    // The notch is only asked for with a word of 68 or more.
    wr(`SDM_ADR_DECIM, 8'h44);
    wr(`SDM_ADR_OP_CTRL, 8'h51);
    rd(`SDM_ADR_OP_CTRL, 8'h51);
    `CHK("hold", 1'b1, ana.filt_hold)
    `CHK("pwr", 1'b1, ana.power)
    `CHK("notch", 1'b1, ana.notch_en)
    `CHK("chop", 1'b1, ana.chop_en)
    `CHK("dword", 8'h44, ana.decim)
    wr(`SDM_ADR_OP_CTRL, 8'h11);
    wr(`SDM_ADR_DECIM, 8'h05);
    repeat (2) @(posedge ref_clk);
    `CHK("notch", 1'b0, ana.notch_en)
    `CHK("dclamp", 8'h0d, ana.decim)
    wr(`SDM_ADR_OP_CTRL, 8'ha9);
    rd(`SDM_ADR_OP_CTRL, 8'h09);
    `CHK("pwr", 1'b0, ana.power)
    `CHK("chop", 1'b0, ana.chop_en)
    `CHK("decim", 8'h05, ana.decim)
    $display("test modes done");
    wr(`SDM_ADR_INPUT_CFG, 8'h07);
    wr(`SDM_ADR_DECIM, 8'h03);
    raw = 24'($urandom);
    filt_data <= raw;
    nrst = 0;
    wr(`SDM_ADR_OP_CTRL, 8'h1a);
    ticks(23);
    wr(`SDM_ADR_OP_CTRL, 8'h1a);
    run(24);
    `CHK("creset", 2, nrst)
    rd(`SDM_ADR_STATUS, 8'h80);
    rd(`SDM_ADR_OP_CTRL, 8'h18);
    rd24(`SDM_ADR_RES_L, raw ^ `SDM_ZERO_BIPOLAR);
    `CHK("pwr", 1'b0, ana.power)
    $display("test single bipolar done");
    wr(`SDM_ADR_INPUT_CFG, 8'h27);
    filt_data <= 24'h800001;
    wr(`SDM_ADR_OP_CTRL, 8'h1a);
    run(24);
    rd(`SDM_ADR_STATUS, 8'h88);
    rd24(`SDM_ADR_RES_L, 24'h000000);
    raw = 24'($urandom) & 24'h3fffff;
    filt_data <= raw;
    wr(`SDM_ADR_OP_CTRL, 8'h1a);
    rd(`SDM_ADR_STATUS, 8'h00);
    run(24);
    rd24(`SDM_ADR_RES_L, raw << 1);
    $display("test single unipolar done");
    wr(`SDM_ADR_INPUT_CFG, 8'h07);
    raw = 24'($urandom);
    filt_data <= raw;
    wr(`SDM_ADR_OP_CTRL, 8'h1b);
    run(24);
    filt_data <= ~raw;
    ticks(24);
    repeat (3) @(posedge ref_clk);
    rd24(`SDM_ADR_RES_L, raw ^ `SDM_ZERO_BIPOLAR);
    wr(`SDM_ADR_STATUS, 8'h00);
    run(24);
    rd24(`SDM_ADR_RES_L, ~raw ^ `SDM_ZERO_BIPOLAR);
    rd(`SDM_ADR_OP_CTRL, 8'h1b);
    wr(`SDM_ADR_OP_CTRL, 8'h18);
    $display("test continuous done");
    for (int c = 4; c < 8; c++) begin
      raw = 24'($urandom);
      filt_data <= raw;
      wr(`SDM_ADR_OP_CTRL, 8'h18 | 8'(c));
      repeat (2) @(posedge ref_clk);
      `CHK("short", c == 4, ana.input_short)
      `CHK("refin", c == 5, ana.ref_to_input)
      `CHK("cdecim", 8'h03, ana.decim)
      run(24);
      rd(`SDM_ADR_STATUS, 8'ha0);
      rd(`SDM_ADR_OP_CTRL, 8'h18);
      rd24(c[0] ? `SDM_ADR_GAIN_L : `SDM_ADR_OFS_L, raw);
    end
    $display("test calibrations done");
    // A write made while the clock enable is low must be lost.
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(`SDM_ADR_INPUT_CFG, 8'h27);
    ce <= 1'b1;
    rd(`SDM_ADR_INPUT_CFG, 8'h07);
    $display("test clock enable done");
    noxref_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr(`SDM_ADR_OP_CTRL, 8'h1a);
    run(24);
    rd(`SDM_ADR_STATUS, 8'h98);
    rd24(`SDM_ADR_RES_L, 24'hffffff);
    noxref_pin <= 1'b0;
    $display("test missing reference done");
    repeat (3) @(posedge ref_clk);
    report_and_stop();
  end
endmodule
